// file: include/fec_consts.vh
// Constants of the flash ECC and check-value engine.
// Assumes inclusion by bare name from the design file.
`ifndef FEC_CONSTS_VH
`define FEC_CONSTS_VH

// ---------------------------------------------
// Link commands (lnk_cmd)
// ---------------------------------------------
`define FEC_CMD_ENTER 3'h1
`define FEC_CMD_START 3'h2
`define FEC_CMD_END 3'h3
`define FEC_CMD_SUSP 3'h4
`define FEC_CMD_RESUME 3'h5
`define FEC_CMD_EXIT 3'h6
`define FEC_CMD_READ 3'h7

// ---------------------------------------------
// Overlay result offsets and status bits
// ---------------------------------------------
`define FEC_OFS_RES_LO 1'h0
`define FEC_OFS_RES_HI 1'h1
`define FEC_SR_ABORT 3
`define FEC_SR_READY 7
`define FEC_SR_SUSP 8
`define FEC_SR_RST 16'h0080

// ---------------------------------------------
// Check-value and ECC values
// ---------------------------------------------
`define FEC_POLY 32'h82f63b78
`define FEC_CRC_INIT 32'hffffffff
`define FEC_CRC_XOR 32'hffffffff
`define FEC_MIN_SPAN 25'h0000002
`define FEC_RES_RST 16'h0000
`define FEC_LOC_RST 24'h000000
`define FEC_CNT_RST 16'h0000
`define FEC_DATA_BIT_TAG 2'h3

`endif

// file: hw/fec_engine.v
// Flash integrity engine: half-page ECC encode/decode and CRC-32C check-value.
// Assumes a synchronous array port (data one cycle after request) and a
// host link whose clock and signals arrive from outside the mclk domain.
`timescale 1ns/1ns
`include "fec_consts.vh"

module fec_engine (
    input wire mclk,
    input wire resetn,
    input wire lnk_clk,
    input wire lnk_cmd_vld,
    input wire [2:0] lnk_cmd,
    input wire [23:0] lnk_addr,
    input wire cfg_ded_en,
    input wire cfg_int_en,
    input wire cfg_stall_en,
    input wire ecc_clr,
    input wire other_aso,
    input wire eac_busy,
    input wire prog_req,
    input wire [20:0] prog_hp,
    input wire [127:0] prog_data,
    input wire prog_hp_used,
    input wire arr_vld,
    input wire [127:0] arr_data,
    input wire [9:0] arr_ecc,
    input wire arr_ecc_off,
    output reg prog_go,
    output reg [20:0] prog_wr_hp,
    output reg [127:0] prog_wr_data,
    output reg [9:0] prog_ecc,
    output reg prog_ecc_off,
    output reg prog_fail,
    output reg arr_rd,
    output reg [20:0] arr_rd_hp,
    output reg rd_vld,
    output reg [15:0] rd_data,
    output reg read_strobe_stall,
    output reg [15:0] status_word,
    output reg [1:0] ecc_status,
    output reg [23:0] ecc_err_addr,
    output reg [15:0] ecc_err_cnt,
    output reg ecc_irq,
    output reg crc_aso_active
);

localparam ST_IDLE = 3'h0;
localparam ST_FETCH = 3'h1;
localparam ST_WAIT = 3'h2;
localparam ST_WORD = 3'h3;
localparam ST_SUSP = 3'h4;

// ---------------------------------------------
// Helpers
// ---------------------------------------------
// Data bit i carries code {11,i}: distinct, never one-hot, so check
// bit flips and data bit flips stay apart.
function [8:0] ecc_chk;
    input [127:0] d;
    integer i;
    reg [8:0] c;
    begin
        c = 9'h000;
        for (i = 0; i < 128; i = i + 1)
            if (d[i])
                c = c ^ {`FEC_DATA_BIT_TAG, i[6:0]};
        ecc_chk = c;
    end
endfunction

// Reflected CRC-32C, bit 0 of the word first
function [31:0] crc_word;
    input [31:0] c;
    input [15:0] d;
    integer i;
    reg [31:0] r;
    begin
        r = c;
        for (i = 0; i < 16; i = i + 1)
            r = (r[0] ^ d[i]) ? ((r >> 1) ^ `FEC_POLY) : (r >> 1);
        crc_word = r;
    end
endfunction

// ---------------------------------------------
// Link synchroniser
// ---------------------------------------------
reg [28:0] lnk_s1;
reg [28:0] lnk_s2;
reg lclk_d;
wire lnk_edge = lnk_s2[28] & ~lclk_d;
wire cmd_take = lnk_edge & lnk_s2[27];
wire [2:0] cmd = lnk_s2[26:24];
wire [23:0] cmd_addr = lnk_s2[23:0];

// Data is synchronised alongside the clock so both are aligned at the edge
always @(posedge mclk or negedge resetn)
begin
    if (!resetn)
    begin
        lnk_s1 <= 29'h0;
        lnk_s2 <= 29'h0;
        lclk_d <= 1'b0;
    end
    else
    begin
        lnk_s1 <= {lnk_clk, lnk_cmd_vld, lnk_cmd, lnk_addr};
        lnk_s2 <= lnk_s1;
        lclk_d <= lnk_s2[28];
    end
end

// ---------------------------------------------
// Half-page decoder
// ---------------------------------------------
reg [127:0] fix;
reg [8:0] syn;
reg corr;
reg unc;
reg podd;

always @*
begin
    fix = arr_data;
    syn = arr_ecc[8:0] ^ ecc_chk(arr_data);
    podd = ^{arr_data, arr_ecc};
    corr = 1'b0;
    unc = 1'b0;
    if (!arr_ecc_off)
    begin
        if (cfg_ded_en && !podd && syn != 9'h000)
            unc = 1'b1;
        else if (syn != 9'h000 || (cfg_ded_en && podd))
        begin
            corr = 1'b1;
            if (syn[8:7] == `FEC_DATA_BIT_TAG)
                fix[syn[6:0]] = ~fix[syn[6:0]];
        end
    end
end

// ---------------------------------------------
// Engine state
// ---------------------------------------------
reg [2:0] state;
reg [23:0] start_location;
reg [23:0] end_location;
reg [23:0] cur;
reg [31:0] crc;
reg [15:0] res_lo;
reg [15:0] res_hi;
reg [127:0] hbuf;
reg susp_pend;
reg hreq_pend;
reg [20:0] hhp;
reg [2:0] hword;
reg owner_crc;
wire [31:0] next_crc = crc_word(crc, hbuf[{cur[2:0], 4'h0} +: 16]);
// Final inversion applied to the full word before it is split into halves
wire [31:0] crc_out = next_crc ^ `FEC_CRC_XOR;
wire host_slot = (state == ST_IDLE) || (state == ST_SUSP);

// Programming path: ECC word built beside the data going to the array
always @(posedge mclk or negedge resetn)
begin
    if (!resetn)
    begin
        prog_go <= 1'b0;
        prog_fail <= 1'b0;
        prog_wr_hp <= 21'h0;
        prog_wr_data <= 128'h0;
        prog_ecc <= 10'h0;
        prog_ecc_off <= 1'b0;
    end
    else
    begin
        prog_go <= 1'b0;
        prog_fail <= 1'b0;
        if (prog_req)
        begin
            if (cfg_ded_en && prog_hp_used)
                prog_fail <= 1'b1;
            else
            begin
                prog_go <= 1'b1;
                prog_wr_hp <= prog_hp;
                prog_wr_data <= prog_data;
                prog_ecc <= {^{prog_data, ecc_chk(prog_data)}, ecc_chk(prog_data)};
                prog_ecc_off <= prog_hp_used;
            end
        end
    end
end

// Array reads, ECC reporting, overlay commands and the CRC walk.
// Later assignments win, so a command overrides the engine step.
always @(posedge mclk or negedge resetn)
begin
    if (!resetn)
    begin
        state <= ST_IDLE;
        start_location <= `FEC_LOC_RST;
        end_location <= `FEC_LOC_RST;
        res_lo <= `FEC_RES_RST;
        res_hi <= `FEC_RES_RST;
        cur <= `FEC_LOC_RST;
        crc <= `FEC_CRC_INIT;
        hbuf <= 128'h0;
        susp_pend <= 1'b0;
        hreq_pend <= 1'b0;
        hhp <= 21'h0;
        hword <= 3'h0;
        owner_crc <= 1'b0;
        arr_rd <= 1'b0;
        arr_rd_hp <= 21'h0;
        rd_vld <= 1'b0;
        rd_data <= 16'h0;
        read_strobe_stall <= 1'b0;
        status_word <= `FEC_SR_RST;
        ecc_status <= 2'h0;
        ecc_err_addr <= `FEC_LOC_RST;
        ecc_err_cnt <= `FEC_CNT_RST;
        ecc_irq <= 1'b0;
        crc_aso_active <= 1'b0;
    end
    else
    begin
        arr_rd <= 1'b0;
        rd_vld <= 1'b0;
        read_strobe_stall <= 1'b0;
        // Sticky error bits: a new error wins over the clear
        ecc_status <= (ecc_clr ? 2'h0 : ecc_status) | ({2{arr_vld}} & {unc, corr});
        ecc_irq <= cfg_int_en && (ecc_status != 2'h0);
        // Host fetches use the array only while the engine is parked
        if (hreq_pend && host_slot)
        begin
            arr_rd <= 1'b1;
            arr_rd_hp <= hhp;
            owner_crc <= 1'b0;
            hreq_pend <= 1'b0;
        end
        if (arr_vld)
        begin
            if (corr || unc)
            begin
                ecc_err_addr <= {arr_rd_hp, 3'h0};
                ecc_err_cnt <= ecc_err_cnt + 16'h0001;
            end
            if (owner_crc)
            begin
                // A fetch answer landing after an exit must not restart the walk
                if (state == ST_WAIT)
                begin
                    hbuf <= fix;
                    state <= ST_WORD;
                end
            end
            else if (unc && cfg_stall_en)
                read_strobe_stall <= 1'b1;
            else
            begin
                rd_data <= fix[{hword, 4'h0} +: 16];
                rd_vld <= 1'b1;
            end
        end
        case (state)
            ST_IDLE: ;
            ST_FETCH:
            begin
                if (susp_pend)
                    state <= ST_SUSP;
                else
                begin
                    arr_rd <= 1'b1;
                    arr_rd_hp <= cur[23:3];
                    owner_crc <= 1'b1;
                    state <= ST_WAIT;
                end
            end
            ST_WAIT: ;
            ST_WORD:
            begin
                crc <= next_crc;
                if (cur == end_location)
                begin
                    res_lo <= crc_out[15:0];
                    res_hi <= crc_out[31:16];
                    status_word[`FEC_SR_READY] <= 1'b1;
                    state <= ST_IDLE;
                end
                else
                begin
                    cur <= cur + 24'h000001;
                    if (cur[2:0] == 3'h7)
                        state <= ST_FETCH;
                end
            end
            ST_SUSP: ;
            default: state <= ST_IDLE;
        endcase
        if (cmd_take)
        begin
            case (cmd)
                `FEC_CMD_ENTER:
                    if (!crc_aso_active && !other_aso && !eac_busy)
                    begin
                        crc_aso_active <= 1'b1;
                        status_word[`FEC_SR_ABORT] <= 1'b0;
                    end
                `FEC_CMD_START:
                    if (crc_aso_active && state == ST_IDLE)
                        start_location <= cmd_addr;
                `FEC_CMD_END:
                    if (crc_aso_active && state == ST_IDLE && !eac_busy && !other_aso)
                    begin
                        end_location <= cmd_addr;
                        res_lo <= `FEC_RES_RST;
                        res_hi <= `FEC_RES_RST;
                        if ({1'b0, cmd_addr} < {1'b0, start_location} + `FEC_MIN_SPAN)
                            status_word[`FEC_SR_ABORT] <= 1'b1;
                        else
                        begin
                            crc <= `FEC_CRC_INIT;
                            cur <= start_location;
                            status_word[`FEC_SR_READY] <= 1'b0;
                            state <= ST_FETCH;
                        end
                    end
                `FEC_CMD_SUSP:
                    if (state != ST_IDLE && state != ST_SUSP)
                    begin
                        susp_pend <= 1'b1;
                        status_word[`FEC_SR_SUSP] <= 1'b1;
                    end
                `FEC_CMD_RESUME:
                    if (status_word[`FEC_SR_SUSP])
                    begin
                        susp_pend <= 1'b0;
                        status_word[`FEC_SR_SUSP] <= 1'b0;
                        if (state == ST_SUSP)
                            state <= ST_FETCH;
                    end
                `FEC_CMD_EXIT:
                begin
                    crc_aso_active <= 1'b0;
                    susp_pend <= 1'b0;
                    status_word[`FEC_SR_SUSP] <= 1'b0;
                    status_word[`FEC_SR_READY] <= 1'b1;
                    state <= ST_IDLE;
                end
                `FEC_CMD_READ:
                    if (crc_aso_active && state != ST_SUSP)
                    begin
                        rd_data <= (cmd_addr[0] == `FEC_OFS_RES_HI) ? res_hi : res_lo;
                        rd_vld <= 1'b1;
                    end
                    else
                    begin
                        hreq_pend <= 1'b1;
                        hhp <= cmd_addr[23:3];
                        hword <= cmd_addr[2:0];
                    end
                default: ;
            endcase
        end
    end
end

endmodule // fec_engine

// file: test/fec_engine_sva.sv
// Port checker for the flash integrity engine.
// Assumes it is bound to fec_engine and sees only the mclk domain.
`timescale 1ns/1ns
module fec_engine_sva (
    input wire mclk,
    input wire resetn,
    input wire cfg_ded_en,
    input wire cfg_int_en,
    input wire prog_req,
    input wire [20:0] prog_hp,
    input wire prog_hp_used,
    input wire arr_vld,
    input wire arr_ecc_off,
    input wire prog_go,
    input wire [20:0] prog_wr_hp,
    input wire prog_ecc_off,
    input wire prog_fail,
    input wire rd_vld,
    input wire read_strobe_stall,
    input wire [15:0] status_word,
    input wire [1:0] ecc_status,
    input wire [23:0] ecc_err_addr,
    input wire [15:0] ecc_err_cnt,
    input wire ecc_irq,
    input wire crc_aso_active
);
    // ---------------------------------------------
    // Program path, error reporting and overlay status
    // ---------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);
    sequence s_fresh; prog_req && !prog_hp_used; endsequence
    sequence s_reuse; prog_req && prog_hp_used; endsequence
    a_prog_fresh: assert property (s_fresh |=> prog_go && !prog_ecc_off && prog_wr_hp == $past(prog_hp))
        else $error("fresh program not passed on");
    a_reuse_default: assert property (s_reuse and !cfg_ded_en |=> prog_go && prog_ecc_off)
        else $error("reprogram kept its checking");
    a_reuse_reject: assert property (s_reuse and cfg_ded_en |=> prog_fail && !prog_go)
        else $error("reprogram not rejected");
    a_irq_follow: assert property (1 |=> ecc_irq == $past(cfg_int_en && ecc_status != 2'h0))
        else $error("interrupt does not follow status");
    a_stall_cause: assert property (read_strobe_stall |-> !rd_vld && $past(arr_vld))
        else $error("stall without array answer");
    a_cnt_cause: assert property ($changed(ecc_err_cnt) |-> $past(arr_vld && !arr_ecc_off))
        else $error("counter moved without checked read");
    a_addr_grain: assert property ($changed(ecc_err_addr) |-> $past(arr_vld) && ecc_err_addr[2:0] == 3'h0)
        else $error("error address not half-page");
    a_abort_ready: assert property ($rose(status_word[3]) |-> status_word[7])
        else $error("abort without ready");
    a_susp_inside: assert property (status_word[8] |-> crc_aso_active)
        else $error("suspended outside overlay");
endmodule // fec_engine_sva

bind fec_engine fec_engine_sva i_sva (.mclk, .resetn, .cfg_ded_en, .cfg_int_en, .prog_req, .prog_hp,
    .prog_hp_used, .arr_vld, .arr_ecc_off, .prog_go, .prog_wr_hp, .prog_ecc_off, .prog_fail, .rd_vld,
    .read_strobe_stall, .status_word, .ecc_status, .ecc_err_addr, .ecc_err_cnt, .ecc_irq, .crc_aso_active);

// file: test/fec_arr_model.sv
// Array model: one programmed half-page, a fixed pattern elsewhere.
// Assumes each arr_rd is answered on the next mclk edge.
`timescale 1ns/1ns
module fec_arr_model (
    input wire mclk,
    input wire resetn,
    input wire arr_rd,
    input wire [20:0] arr_rd_hp,
    input wire prog_go,
    input wire [20:0] prog_wr_hp,
    input wire [127:0] prog_wr_data,
    input wire [9:0] prog_ecc,
    input wire prog_ecc_off,
    input wire [127:0] flip,
    output reg arr_vld,
    output reg [127:0] arr_data,
    output reg [9:0] arr_ecc,
    output reg arr_ecc_off
);
    reg [20:0] st_hp;
    reg [138:0] st;
    integer w;
    // ---------------------------------------------
    // Storage and answer
    // ---------------------------------------------
    // Idle data lines toggle so stale words are never mistaken for answers
    always @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            st_hp <= 21'h1fffff;
            arr_vld <= 1'b0;
            arr_data <= 128'h0;
        end
        else
        begin
            if (prog_go)
            begin
                st_hp <= prog_wr_hp;
                st <= {prog_ecc_off, prog_ecc, prog_wr_data};
            end
            arr_vld <= arr_rd;
            arr_data <= ~arr_data;
            arr_ecc_off <= 1'b1;
            if (arr_rd && arr_rd_hp == st_hp)
                {arr_ecc_off, arr_ecc, arr_data} <= st ^ {11'h0, flip};
            else if (arr_rd)
                for (w = 0; w < 8; w = w + 1)
                    arr_data[w*16 +: 16] <= ({arr_rd_hp, 3'h0} + w) * 16'h9e37 + 16'h1234;
        end
    end
endmodule // fec_arr_model

// file: test/tb.sv
// Self-checking bench for the flash integrity engine.
// Assumes the engine, its checker and the array model are compiled first.
`timescale 1ns/1ns
`include "fec_consts.vh"
module tb;
    reg mclk, resetn, lnk_clk, lnk_cmd_vld, cfg_ded_en, cfg_int_en, cfg_stall_en, ecc_clr, other_aso, eac_busy;
    reg prog_req, prog_hp_used, stl;
    reg [2:0] lnk_cmd;
    reg [23:0] lnk_addr;
    reg [20:0] prog_hp;
    reg [127:0] prog_data, flip;
    reg [15:0] got;
    wire arr_rd, arr_vld, arr_ecc_off, prog_go, prog_ecc_off, prog_fail, rd_vld, read_strobe_stall, ecc_irq;
    wire crc_aso_active;
    wire [20:0] arr_rd_hp, prog_wr_hp;
    wire [127:0] arr_data, prog_wr_data;
    wire [9:0] arr_ecc, prog_ecc;
    wire [15:0] rd_data, status_word, ecc_err_cnt;
    wire [1:0] ecc_status;
    wire [23:0] ecc_err_addr;
    integer errors, checks, i, n;
    fec_engine i_dut (.mclk, .resetn, .lnk_clk, .lnk_cmd_vld, .lnk_cmd, .lnk_addr, .cfg_ded_en, .cfg_int_en,
        .cfg_stall_en, .ecc_clr, .other_aso, .eac_busy, .prog_req, .prog_hp, .prog_data, .prog_hp_used,
        .arr_vld, .arr_data, .arr_ecc, .arr_ecc_off, .prog_go, .prog_wr_hp, .prog_wr_data, .prog_ecc,
        .prog_ecc_off, .prog_fail, .arr_rd, .arr_rd_hp, .rd_vld, .rd_data, .read_strobe_stall, .status_word,
        .ecc_status, .ecc_err_addr, .ecc_err_cnt, .ecc_irq, .crc_aso_active);
    fec_arr_model i_arr (.mclk, .resetn, .arr_rd, .arr_rd_hp, .prog_go, .prog_wr_hp, .prog_wr_data,
        .prog_ecc, .prog_ecc_off, .flip, .arr_vld, .arr_data, .arr_ecc, .arr_ecc_off);
    // ---------------------------------------------
    // Expectations and helpers
    // ---------------------------------------------
    function [15:0] pw(input [23:0] a);
        pw = a * 16'h9e37 + 16'h1234;
    endfunction
    // Reflected bitwise form, low bit of each word first
    function [31:0] crc_exp(input [23:0] s, input [23:0] e);
        reg [31:0] c;
        reg [15:0] d;
        integer a, b;
    begin
        c = 32'hffffffff;
        for (a = s; a <= e; a = a + 1)
        begin
            d = pw(a);
            for (b = 0; b < 16; b = b + 1)
                c = (c >> 1) ^ ((c[0] ^ d[b]) ? `FEC_POLY : 32'h0);
        end
        crc_exp = ~c;
    end
    endfunction
    task chk(input [31:0] g, input [31:0] x);
    begin
        checks = checks + 1;
        if (g !== x)
        begin
            errors = errors + 1;
            $display("mismatch at %0t: got %h expected %h", $time, g, x);
        end
    end
    endtask
    task stop_test;
    begin
        if (errors == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    end
    endtask
    // Two 800 ns link periods per command: the first carries it, the second waits for the answer
    task cmd(input [2:0] c, input [23:0] a);
    begin
        got = 16'hxxxx;
        stl = 1'b0;
        for (n = 0; n < 16; n = n + 1)
        begin
            @(posedge mclk);
            lnk_cmd <= c;
            lnk_addr <= a;
            lnk_cmd_vld <= (n < 8);
            lnk_clk <= (n % 8 >= 4);
            @(negedge mclk);
            if (rd_vld || read_strobe_stall)
            begin
                got = rd_data;
                stl = read_strobe_stall;
            end
        end
    end
    endtask
    task crc_run(input [23:0] s, input [23:0] e, input sus);
        integer t;
    begin
        cmd(`FEC_CMD_ENTER, 24'h0);
        cmd(`FEC_CMD_START, s);
        cmd(`FEC_CMD_END, e);
        if (sus)
        begin
            chk(status_word[7], 1'b0);
            cmd(`FEC_CMD_READ, 24'h0);
            chk(got, 16'h0);
            cmd(`FEC_CMD_SUSP, 24'h0);
            chk(status_word[8], 1'b1);
            cmd(`FEC_CMD_READ, 24'h4d);
            chk(got, pw(24'h4d));
            cmd(`FEC_CMD_RESUME, 24'h0);
        end
        for (t = 0; t < 3000 && !status_word[7]; t = t + 1)
            @(negedge mclk);
        if (t == 3000)
        begin
            chk(1, 0);
            stop_test;
        end
        cmd(`FEC_CMD_READ, 24'h0);
        chk(got, crc_exp(s, e) & 32'hffff);
        cmd(`FEC_CMD_READ, 24'h1);
        chk(got, crc_exp(s, e) >> 16);
        cmd(`FEC_CMD_EXIT, 24'h0);
        chk(crc_aso_active, 1'b0);
    end
    endtask
    task prog(input used);
    begin
        @(posedge mclk);
        prog_req <= 1'b1;
        prog_hp_used <= used;
        @(posedge mclk);
        prog_req <= 1'b0;
        @(negedge mclk);
        chk({prog_go, prog_fail}, {!(used && cfg_ded_en), used && cfg_ded_en});
    end
    endtask
    initial
    begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    // ---------------------------------------------
    // Main sequence
    // ---------------------------------------------
    initial
    begin
        {resetn, lnk_clk, lnk_cmd_vld, cfg_ded_en, cfg_int_en, cfg_stall_en, ecc_clr, other_aso, eac_busy} = 9'h0;
        {prog_req, prog_hp_used, lnk_cmd, lnk_addr, flip} = 0;
        errors = 0;
        checks = 0;
        n = $urandom(73);
        prog_hp = 21'h5;
        prog_data = {$urandom, $urandom, $urandom, $urandom};
        repeat (2) @(posedge mclk);
        resetn <= 1'b1;
        crc_run(24'h8, 24'ha, 1'b0);
        crc_run(24'h7, 24'h9, 1'b0);
        for (i = 0; i < 4; i = i + 1)
            crc_run(24'h0 + $urandom % 300, 24'h12c + $urandom % 40, 1'b0);
        crc_run(24'h0, 24'h3e8, 1'b1);
        cmd(`FEC_CMD_ENTER, 24'h0);
        cmd(`FEC_CMD_START, 24'h14);
        cmd(`FEC_CMD_END, 24'h15);
        chk(status_word[7:3] & 5'h11, 5'h11);
        cmd(`FEC_CMD_EXIT, 24'h0);
        other_aso <= 1'b1;
        cmd(`FEC_CMD_ENTER, 24'h0);
        chk(crc_aso_active, 1'b0);
        other_aso <= 1'b0;
        eac_busy <= 1'b1;
        cmd(`FEC_CMD_ENTER, 24'h0);
        chk(crc_aso_active, 1'b0);
        eac_busy <= 1'b0;
        cmd(`FEC_CMD_ENTER, 24'h0);
        cmd(`FEC_CMD_START, 24'h0);
        cmd(`FEC_CMD_END, 24'h258);
        resetn <= 1'b0;
        @(posedge mclk);
        resetn <= 1'b1;
        @(negedge mclk);
        chk({crc_aso_active, status_word}, 17'h00080);
        cmd(`FEC_CMD_ENTER, 24'h0);
        cmd(`FEC_CMD_READ, 24'h1);
        chk(got, 16'h0);
        cmd(`FEC_CMD_EXIT, 24'h0);
        prog(1'b0);
        flip <= 128'h1 << 37;
        cmd(`FEC_CMD_READ, 24'h2a);
        chk(got, prog_data[47:32]);
        chk({ecc_status[0], ecc_err_addr, ecc_err_cnt}, {1'b1, 24'h28, 16'h1});
        cfg_ded_en <= 1'b1;
        cfg_stall_en <= 1'b1;
        cfg_int_en <= 1'b1;
        flip <= 128'h3 << 37;
        cmd(`FEC_CMD_READ, 24'h29);
        chk({stl, ecc_status[1], ecc_irq}, 3'h7);
        ecc_clr <= 1'b1;
        @(posedge mclk);
        ecc_clr <= 1'b0;
        repeat (2) @(negedge mclk);
        chk({ecc_status, ecc_irq}, 3'h0);
        prog(1'b1);
        cfg_ded_en <= 1'b0;
        prog(1'b1);
        // Reprogrammed half-page: the flipped bit comes back uncorrected and uncounted
        flip <= 128'h1 << 37;
        cmd(`FEC_CMD_READ, 24'h2a);
        chk({got, ecc_err_cnt}, {prog_data[47:32] ^ 16'h0020, 16'h2});
        stop_test;
    end
endmodule // tb
